//--- common/epi_pkg.sv
// constants, register map and sense encodings for the external pin interrupt block
package epi_pkg;

   // pin counts
   localparam int EPI_DED_PINS = 8;
   localparam int EPI_LOW_PINS = 4;
   localparam int EPI_PC_PINS = 8;

   // apb register byte offsets
   localparam logic [11:0] EPI_OFF_SENSE_LOW = 12'h000;
   localparam logic [11:0] EPI_OFF_SENSE_HIGH = 12'h004;
   localparam logic [11:0] EPI_OFF_DED_MASK = 12'h008;
   localparam logic [11:0] EPI_OFF_DED_FLAG = 12'h00c;
   localparam logic [11:0] EPI_OFF_PC_CTRL = 12'h010;
   localparam logic [11:0] EPI_OFF_PC_FLAG = 12'h014;
   localparam logic [11:0] EPI_OFF_PC_MASK = 12'h018;
   localparam logic [11:0] EPI_OFF_PIN_STATE = 12'h01c;

   // reset values
   localparam logic [7:0] EPI_RST_SENSE_LOW = 8'h00;
   localparam logic [7:0] EPI_RST_SENSE_HIGH = 8'h00;
   localparam logic [7:0] EPI_RST_DED_MASK = 8'h00;
   localparam logic [7:0] EPI_RST_DED_FLAG = 8'h00;
   localparam logic [7:0] EPI_RST_PC_MASK = 8'h00;
   localparam logic EPI_RST_PC_EN = 1'b0;
   localparam logic EPI_RST_PC_FLAG = 1'b0;

   // field positions
   localparam int EPI_GRP_EN_BIT = 0;
   localparam int EPI_PC_FLAG_BIT = 0;
   localparam int EPI_SENSE_W = 2;

   // timing: clock period and least asynchronous pulse width
   localparam int EPI_CLK_NS = 40;
   localparam int EPI_MIN_PULSE_NS = 50;
   localparam int EPI_MIN_PULSE_CYC = (EPI_MIN_PULSE_NS + EPI_CLK_NS - 1) / EPI_CLK_NS;

   // two-bit sense selection codes
   typedef enum logic [1:0] {
      EPI_SENSE_LEVEL = 2'h0,
      EPI_SENSE_ANY = 2'h1,
      EPI_SENSE_FALL = 2'h2,
      EPI_SENSE_RISE = 2'h3
   } epi_sense_e;

endpackage

//--- src/epi_async_catch.sv
// clockless edge catcher: pin edges set a latch that the clocked side clears
module epi_async_catch (
   // pin and edge selection
   input wire logic pin_in,
   input wire logic rise_en_in,
   input wire logic fall_en_in,
   // clear from the clocked side, raised once the catch has been seen, held until it is seen cleared
   input wire logic clear_in,
   // caught edge, asynchronous level
   output logic caught_out
);

   logic rise_seen;
   logic fall_seen;

   // rising edge catch, works with the i/o clock stopped
   always_ff @(posedge pin_in or posedge clear_in) begin
      if (clear_in) begin
         rise_seen <= 1'b0;
      end else begin
         rise_seen <= rise_en_in;
      end
   end

   // falling edge catch
   always_ff @(negedge pin_in or posedge clear_in) begin
      if (clear_in) begin
         fall_seen <= 1'b0;
      end else begin
         fall_seen <= fall_en_in;
      end
   end

   assign caught_out = rise_seen | fall_seen;

endmodule

//--- src/epi_sync2.sv
// two flip-flop synchroniser for a vector of independent levels
module epi_sync2 #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // asynchronous levels and their synchronised copy
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);

   logic [WIDTH-1:0] meta;

   initial begin
      if (WIDTH < 1) $error("epi_sync2: WIDTH must be at least 1");
   end

   // first stage is read only by the second stage
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         meta <= '0;
         q_out <= '0;
      end else begin
         meta <= d_in;
         q_out <= meta;
      end
   end

endmodule

//--- src/epi_top.sv
// external pin interrupt controller: dedicated pins, pin-change group, apb registers
// What this block does
// - pins raise requests from any activity, even when software drives them as outputs.
// - grouped change request follows toggles on inputs whose mask bit is set only.
// - pin-change activity is caught without the i/o clock, waking from any sleep.
// - enabled level-sensed pin keeps requesting for as long as it stays low.
// - upper four pins detect edges only while the i/o clock runs.
// - low levels on all pins and lower-pin edges are detected asynchronously.
// - level wake needs the level held through start-up, else wake without interrupt.
// - lower pin interrupt needs both the global enable and its mask bit.
// - lower-pin edge catcher registers pulses wider than about 50 ns.
// - lower sense codes: 00 low, 01 any edge, 10 falling, 11 rising.
// - writing one to a flag bit clears it; writing zero leaves it.
// - lower sense register holds four two-bit fields, highest pin at the top.
// - upper pins are sampled; 00 low, 01 change, 10 falling, 11 rising.
// - flag sets on a triggering edge and clears when the handler is entered.
// - flag is held cleared while its pin is set for level sensing.
// - each change mask bit enables its input; group enable also required.
//
// The APB register port and the address map are this design's own decisions.
module epi_top
   import epi_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // pins
   input wire logic [EPI_DED_PINS-1:0] dedicated_irq_pin_in,
   input wire logic [EPI_PC_PINS-1:0] pin_change_input_in,
   // processor side
   input wire logic global_irq_enable_in,
   input wire logic [EPI_DED_PINS-1:0] dedicated_ack_in,
   input wire logic change_ack_in,
   output logic [EPI_DED_PINS-1:0] dedicated_irq_out,
   output logic grouped_change_request_out,
   output logic wake_out
);

   localparam int SYNC_W = EPI_DED_PINS + EPI_LOW_PINS + EPI_PC_PINS;

   // software registers
   logic [7:0] sense_control_low_pins;
   logic [7:0] sense_control_high_pins;
   logic [EPI_DED_PINS-1:0] dedicated_mask_reg;
   logic [EPI_DED_PINS-1:0] dedicated_flag_reg;
   logic [EPI_PC_PINS-1:0] change_mask_reg;
   logic group_change_enable;
   logic change_flag;

   // detection state
   logic [EPI_LOW_PINS-1:0] low_caught;
   logic [EPI_PC_PINS-1:0] pc_caught;
   logic [SYNC_W-1:0] sync_q;
   logic [EPI_DED_PINS-1:0] pin_s;
   logic [EPI_LOW_PINS-1:0] low_caught_s;
   logic [EPI_PC_PINS-1:0] pc_caught_s;
   logic [EPI_LOW_PINS-1:0] low_caught_prev;
   logic [EPI_PC_PINS-1:0] pc_caught_prev;
   logic [EPI_DED_PINS-1:0] pin_prev;
   logic [15:0] sense_all;

   // derived terms
   logic [EPI_DED_PINS-1:0] level_mode;
   logic [EPI_DED_PINS-1:0] level_req;
   logic [EPI_DED_PINS-1:0] ded_set;
   logic [EPI_DED_PINS-1:0] ded_clr;
   logic [EPI_LOW_PINS-1:0] low_evt;
   logic [EPI_PC_PINS-1:0] pc_evt;
   logic pc_set;
   logic pc_clr;
   logic bus_wr;
   logic bus_setup;
   logic addr_hit;
   logic [7:0] rd_word;

   initial begin
      if (EPI_LOW_PINS * EPI_SENSE_W != 8) $error("epi_top: four lower pins per sense register");
      if (EPI_MIN_PULSE_CYC < 1) $error("epi_top: pulse width below one cycle");
   end

   // one two-bit field per pin, highest pin in the top bits of each register
   assign sense_all = {sense_control_high_pins, sense_control_low_pins};

   // ---------------- asynchronous capture ----------------

   // lower pins: edges latched straight off the pin so that deep sleep can be left
   for (genvar i = 0; i < EPI_LOW_PINS; i++) begin : g_low
      epi_sense_e mode;
      assign mode = epi_sense_e'(sense_all[2*i +: 2]);
      epi_async_catch u_catch (
         .pin_in(dedicated_irq_pin_in[i]),
         .rise_en_in(mode == EPI_SENSE_ANY || mode == EPI_SENSE_RISE),
         .fall_en_in(mode == EPI_SENSE_ANY || mode == EPI_SENSE_FALL),
         .clear_in(reset_in | low_caught_s[i]),
         .caught_out(low_caught[i])
      );
   end

   // pin-change inputs: both edges, only where the mask bit lets the input in
   for (genvar i = 0; i < EPI_PC_PINS; i++) begin : g_pc
      epi_async_catch u_catch (
         .pin_in(pin_change_input_in[i]),
         .rise_en_in(change_mask_reg[i]),
         .fall_en_in(change_mask_reg[i]),
         .clear_in(reset_in | pc_caught_s[i]),
         .caught_out(pc_caught[i])
      );
   end

   // every asynchronous level enters the clock domain through two flops
   // pins travel inverted: the synchroniser clears to zero, so the synced pin
   // reads high in and just after reset, matching pin_prev and the idle level
   epi_sync2 #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .d_in({pc_caught, low_caught, ~dedicated_irq_pin_in}),
      .q_out(sync_q)
   );

   assign pin_s = ~sync_q[EPI_DED_PINS-1:0];
   assign low_caught_s = sync_q[EPI_DED_PINS +: EPI_LOW_PINS];
   assign pc_caught_s = sync_q[EPI_DED_PINS + EPI_LOW_PINS +: EPI_PC_PINS];

   // previous samples; an edge of a synchronised catch is one event
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         low_caught_prev <= '0;
         pc_caught_prev <= '0;
         pin_prev <= '1;
      end else begin
         low_caught_prev <= low_caught_s;
         pc_caught_prev <= pc_caught_s;
         pin_prev <= pin_s;
      end
   end

   assign low_evt = low_caught_s & ~low_caught_prev;
   assign pc_evt = pc_caught_s & ~pc_caught_prev;

   // ---------------- per-pin sense decode ----------------

   // the pin is read as an input whatever its direction, so writes to it also trigger
   always_comb begin
      epi_sense_e m;
      m = EPI_SENSE_LEVEL;
      for (int i = 0; i < EPI_DED_PINS; i++) begin
         m = epi_sense_e'(sense_all[2*i +: 2]);
         level_mode[i] = (m == EPI_SENSE_LEVEL);
         level_req[i] = level_mode[i] & ~pin_s[i];
         if (i < EPI_LOW_PINS) begin
            ded_set[i] = low_evt[i] & ~level_mode[i];
         end else begin
            // upper pins: compare two clock samples, needs a running clock
            case (m)
               EPI_SENSE_ANY: ded_set[i] = pin_s[i] ^ pin_prev[i];
               EPI_SENSE_FALL: ded_set[i] = pin_prev[i] & ~pin_s[i];
               EPI_SENSE_RISE: ded_set[i] = ~pin_prev[i] & pin_s[i];
               default: ded_set[i] = 1'b0;
            endcase
         end
      end
   end

   // ---------------- apb slave ----------------

   // zero wait states: the access phase always completes in its first cycle
   assign bus_setup = psel_in & ~penable_in;
   assign bus_wr = psel_in & penable_in & pwrite_in & pstrb_in[0];
   assign pready_out = psel_in & penable_in;

   always_comb begin
      addr_hit = 1'b1;
      rd_word = 8'h00;
      case (paddr_in)
         EPI_OFF_SENSE_LOW: rd_word = sense_control_low_pins;
         EPI_OFF_SENSE_HIGH: rd_word = sense_control_high_pins;
         EPI_OFF_DED_MASK: rd_word = dedicated_mask_reg;
         EPI_OFF_DED_FLAG: rd_word = dedicated_flag_reg;
         EPI_OFF_PC_CTRL: rd_word = {7'h00, group_change_enable};
         EPI_OFF_PC_FLAG: rd_word = {7'h00, change_flag};
         EPI_OFF_PC_MASK: rd_word = change_mask_reg;
         EPI_OFF_PIN_STATE: rd_word = pin_s;
         default: addr_hit = 1'b0;
      endcase
   end

   // unmapped addresses answer with an error and read as zero
   assign pslverr_out = pready_out & ~addr_hit;

   // read data captured in the setup cycle so the output comes from a flop
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         prdata_out <= 32'h0000_0000;
      end else if (bus_setup) begin
         prdata_out <= {24'h00_0000, rd_word};
      end
   end

   // plain read/write control registers; only byte lane 0 carries data
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         sense_control_low_pins <= EPI_RST_SENSE_LOW;
         sense_control_high_pins <= EPI_RST_SENSE_HIGH;
         dedicated_mask_reg <= EPI_RST_DED_MASK;
         change_mask_reg <= EPI_RST_PC_MASK;
         group_change_enable <= EPI_RST_PC_EN;
      end else if (bus_wr) begin
         case (paddr_in)
            EPI_OFF_SENSE_LOW: sense_control_low_pins <= pwdata_in[7:0];
            EPI_OFF_SENSE_HIGH: sense_control_high_pins <= pwdata_in[7:0];
            EPI_OFF_DED_MASK: dedicated_mask_reg <= pwdata_in[7:0];
            EPI_OFF_PC_MASK: change_mask_reg <= pwdata_in[7:0];
            EPI_OFF_PC_CTRL: group_change_enable <= pwdata_in[EPI_GRP_EN_BIT];
            default: ;
         endcase
      end
   end

   // ---------------- flags ----------------

   // clears from a one written by software or from handler entry
   assign ded_clr = ((bus_wr && paddr_in == EPI_OFF_DED_FLAG) ? pwdata_in[7:0] : 8'h00)
                    | dedicated_ack_in;
   assign pc_clr = (bus_wr && paddr_in == EPI_OFF_PC_FLAG && pwdata_in[EPI_PC_FLAG_BIT])
                   | change_ack_in;
   assign pc_set = |pc_evt;

   // set wins over a clear in the same cycle so no event is lost
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         dedicated_flag_reg <= EPI_RST_DED_FLAG;
      end else begin
         dedicated_flag_reg <= ((dedicated_flag_reg & ~ded_clr) | ded_set) & ~level_mode;
      end
   end

   // grouped change flag
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         change_flag <= EPI_RST_PC_FLAG;
      end else begin
         change_flag <= (change_flag & ~pc_clr) | pc_set;
      end
   end

   // ---------------- requests and wake ----------------

   // level sources request for as long as the synchronised pin stays low
   assign dedicated_irq_out = (dedicated_flag_reg | level_req) & dedicated_mask_reg
                              & {EPI_DED_PINS{global_irq_enable_in}};
   assign grouped_change_request_out = change_flag & group_change_enable
                                       & global_irq_enable_in;

   // wake works with the clock stopped, so it reads the catches and pins directly;
   // a level that vanishes before start-up ends still wakes but leaves no request
   assign wake_out = (|(low_caught & dedicated_mask_reg[EPI_LOW_PINS-1:0]))
                     | (|(~dedicated_irq_pin_in & level_mode & dedicated_mask_reg))
                     | ((|pc_caught) & group_change_enable);

   // ---------------- assertions ----------------

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   AST_GIE_GATES: assert property (
      !global_irq_enable_in |-> (dedicated_irq_out == 8'h00) && !grouped_change_request_out)
      else $error("request raised without global enable");

   AST_LEVEL_HOLDS: assert property (
      (level_mode[0] && dedicated_mask_reg[0] && global_irq_enable_in && !pin_s[0])
      |-> dedicated_irq_out[0])
      else $error("level request dropped while pin low");

   AST_LEVEL_FLAG_CLEAR: assert property (
      ##1 (dedicated_flag_reg & $past(level_mode)) == 8'h00)
      else $error("flag set while pin in level mode");

   AST_W1C: assert property (
      (bus_wr && paddr_in == EPI_OFF_DED_FLAG)
      |=> (dedicated_flag_reg & $past(pwdata_in[7:0] & ~ded_set)) == 8'h00)
      else $error("written one did not clear flag");

   AST_W0_KEEPS: assert property (
      (bus_wr && paddr_in == EPI_OFF_DED_FLAG && dedicated_ack_in == 8'h00)
      |=> (($past(dedicated_flag_reg & ~pwdata_in[7:0] & ~level_mode))
           & ~dedicated_flag_reg) == 8'h00)
      else $error("written zero changed flag");

   AST_UPPER_RISE: assert property (
      (sense_all[15:14] == 2'h3 && !pin_prev[7] && pin_s[7]) |=> dedicated_flag_reg[7])
      else $error("rising edge on pin 7 not flagged");

   AST_UPPER_FALL: assert property (
      (sense_all[13:12] == 2'h2 && pin_prev[6] && !pin_s[6]) |=> dedicated_flag_reg[6])
      else $error("falling edge on pin 6 not flagged");

   AST_LOWER_EDGE_LATENCY: assert property (
      ($rose(low_caught[1]) && sense_all[3:2] == 2'h1 && !dedicated_ack_in[1])
      ##0 (sense_all[3:2] == 2'h1) [*4] |-> dedicated_flag_reg[1])
      else $error("lower pin edge not flagged within four cycles");

   AST_PC_SET: assert property (
      (pc_evt != 8'h00) |=> change_flag)
      else $error("masked change did not set group flag");

   AST_PC_REQ: assert property (
      grouped_change_request_out |-> change_flag && group_change_enable)
      else $error("group request without flag and enable");

   AST_ACK_CLEARS: assert property (
      (dedicated_ack_in[5] && !ded_set[5]) |=> !dedicated_flag_reg[5])
      else $error("handler entry did not clear flag");

   AST_WAKE: assert property (
      (low_caught[1] && dedicated_mask_reg[1]) |-> wake_out)
      else $error("caught edge did not wake");

   AST_APB_ONE_CYCLE: assert property (
      bus_setup |=> !penable_in || pready_out)
      else $error("access phase not answered at once");

   COV_LOW_EDGE: cover property (low_evt[1] ##1 dedicated_irq_out[1]);
   COV_UPPER_FALL: cover property (sense_all[13:12] == 2'h2 && ded_set[6]);
   COV_PC_REQ: cover property (pc_set ##1 grouped_change_request_out);
   COV_LEVEL_REQ: cover property (level_req[4] && dedicated_irq_out[4]);

endmodule

//--- verification/epi_pin_model.sv
// far-side model: external sources driving the dedicated and pin-change pins
module epi_pin_model (
   // clock
   input wire logic clk_in,
   // pin levels seen by the block
   output logic [7:0] ded_pins_out,
   output logic [7:0] pc_pins_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // dedicated pins idle high as with a pull-up; change inputs start low
   initial begin
      ded_pins_out = 8'hff;
      pc_pins_out = 8'h00;
   end

   // levels stand until the next call, long past one instruction and start-up
   task automatic drive(input logic [7:0] ded, input logic [7:0] pc);
      @(posedge clk_in);
      ded_pins_out <= ded;
      pc_pins_out <= pc;
   endtask

   // low pulse of whole cycles; one cycle is shorter than the async minimum
   task automatic pulse(input logic [7:0] sel, input int cycles);
      @(posedge clk_in);
      ded_pins_out <= ded_pins_out & ~sel;
      repeat (cycles) @(posedge clk_in);
      ded_pins_out <= ded_pins_out | sel;
   endtask
endmodule

//--- verification/external_pin_interrupts_tb.sv
// self-checking testbench for the external pin interrupt block
module external_pin_interrupts_tb
   import epi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, grp_req, wake;
   logic gie = 1'b0, cack = 1'b0;
   logic [7:0] ack = 8'h00;
   logic [7:0] irq, ded_pins, pc_pins;
   int n_errors = 0;
   int n_checks = 0;

   // 25 MHz clock
   initial begin
      forever #20 clk_in = ~clk_in;
   end

   epi_top i_epi_top (
      .clk_in(clk_in), .reset_in(reset_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .dedicated_irq_pin_in(ded_pins), .pin_change_input_in(pc_pins),
      .global_irq_enable_in(gie), .dedicated_ack_in(ack), .change_ack_in(cack),
      .dedicated_irq_out(irq), .grouped_change_request_out(grp_req), .wake_out(wake)
   );

   epi_pin_model i_epi_pin_model (
      .clk_in(clk_in), .ded_pins_out(ded_pins), .pc_pins_out(pc_pins)
   );

   // compare, count and report at once
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // one apb transfer; request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int i;
      @(posedge clk_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk_in);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk_in);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (i >= 50) n_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf);
   endtask

   task automatic rc(input logic [11:0] a, input logic [31:0] exp, input string name);
      apb(1'b0, a, 32'h0, 4'hf);
      check(name, rd, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // watchdog: the whole sequence needs well under 1000 cycles
   initial begin
      #(40 * 5000);
      n_errors++;
      close_out();
   end

   // main sequence
   initial begin
      repeat (2) @(posedge clk_in);
      reset_in <= 1'b0;
      // every control register, mask and flag starts cleared
      for (int k = 0; k < 7; k++) rc(12'(k * 4), 32'h0, "reset value");
      apb(1'b0, 12'h020, 32'h0, 4'hf);
      check("unmapped error", {31'h0, err}, 32'h1);
      check("unmapped data", rd, 32'h0);
      // sense fields, pin 3 at the top: 11 10 01 00
      wr(EPI_OFF_SENSE_LOW, 32'he4);
      rc(EPI_OFF_SENSE_LOW, 32'he4, "sense low");
      apb(1'b1, EPI_OFF_SENSE_HIGH, 32'h55, 4'h0);
      rc(EPI_OFF_SENSE_HIGH, 32'h0, "strobe off write");
      wr(EPI_OFF_SENSE_HIGH, 32'he4);
      rc(EPI_OFF_SENSE_HIGH, 32'he4, "sense high");
      wr(EPI_OFF_DED_FLAG, 32'hff);
      wr(EPI_OFF_DED_MASK, 32'hff);
      gie <= 1'b1;
      // all pins fall: any and fall modes flag, level modes request only
      i_epi_pin_model.drive(8'h00, 8'h00);
      cyc(8);
      rc(EPI_OFF_DED_FLAG, 32'h66, "flags after fall");
      check("irq after fall", {24'h0, irq}, 32'h77);
      // edge pins rise, level pins stay low
      i_epi_pin_model.drive(8'hee, 8'h00);
      cyc(8);
      rc(EPI_OFF_DED_FLAG, 32'hee, "flags after rise");
      rc(EPI_OFF_PIN_STATE, 32'hee, "pin levels");
      ack <= 8'h28;
      @(posedge clk_in);
      ack <= 8'h00;
      cyc(3);
      rc(EPI_OFF_DED_FLAG, 32'hc6, "flags after ack");
      wr(EPI_OFF_DED_FLAG, 32'h22);
      rc(EPI_OFF_DED_FLAG, 32'hc4, "flags after w1c");
      gie <= 1'b0;
      cyc(2);
      check("irq gie off", {24'h0, irq}, 32'h0);
      gie <= 1'b1;
      wr(EPI_OFF_DED_MASK, 32'h0f);
      cyc(1);
      check("irq lower mask", {24'h0, irq}, 32'h05);
      // level withdrawn: level request ends, edge flag stays
      i_epi_pin_model.drive(8'hff, 8'h00);
      cyc(4);
      check("irq level gone", {24'h0, irq}, 32'h04);
      wr(EPI_OFF_DED_FLAG, 32'hff);
      rc(EPI_OFF_DED_FLAG, 32'h0, "flags cleared");
      // two-cycle pulses, 80 ns, on a lower and an upper falling-edge pin
      i_epi_pin_model.pulse(8'h44, 2);
      cyc(6);
      rc(EPI_OFF_DED_FLAG, 32'h44, "pulse flags");
      // pin-change group: inputs 3..0 masked in
      wr(EPI_OFF_PC_MASK, 32'h0f);
      wr(EPI_OFF_PC_CTRL, 32'h1);
      i_epi_pin_model.drive(8'hff, 8'h20);
      cyc(6);
      rc(EPI_OFF_PC_FLAG, 32'h0, "masked-out toggle");
      check("group req masked", {31'h0, grp_req}, 32'h0);
      i_epi_pin_model.drive(8'hff, 8'h24);
      #1;
      check("wake on change", {31'h0, wake}, 32'h1);
      cyc(6);
      rc(EPI_OFF_PC_FLAG, 32'h1, "masked-in toggle");
      check("group req", {31'h0, grp_req}, 32'h1);
      gie <= 1'b0;
      cyc(1);
      check("group req gie off", {31'h0, grp_req}, 32'h0);
      gie <= 1'b1;
      wr(EPI_OFF_PC_CTRL, 32'h0);
      cyc(1);
      check("group req disabled", {31'h0, grp_req}, 32'h0);
      wr(EPI_OFF_PC_CTRL, 32'h1);
      cyc(1);
      check("group req enabled", {31'h0, grp_req}, 32'h1);
      cack <= 1'b1;
      @(posedge clk_in);
      cack <= 1'b0;
      cyc(2);
      check("group req after ack", {31'h0, grp_req}, 32'h0);
      i_epi_pin_model.drive(8'hff, 8'h00);
      cyc(6);
      rc(EPI_OFF_PC_FLAG, 32'h1, "toggle back");
      wr(EPI_OFF_PC_FLAG, 32'h1);
      rc(EPI_OFF_PC_FLAG, 32'h0, "group flag w1c");
      close_out();
   end
endmodule
